// ---- sfcr_regs.sv ----
/*
  sequencer control, result queue configuration, checksum and timeout
  registers, plus the command fetch engine they steer.
  assumes the command and result queue storage sit outside, and that
  aclk_tick is a one-cycle pulse per timer clock period, synchronous to clk.
*/
module sfcr_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // sequencer register writes
  input  wire logic        seq_wr,
  input  wire logic [15:0] seq_addr,
  input  wire logic [31:0] seq_wdata,
  // timer clock tick
  input  wire logic        aclk_tick,
  // command queue
  input  wire logic        cmd_empty,
  input  wire logic [31:0] cmd_data,
  input  wire logic        cmd_is_write,
  output logic             cmd_pop,
  // executed command
  output logic             exec_valid,
  output logic [31:0]      exec_word,
  // accelerator result
  input  wire logic        res_valid,
  input  wire logic [29:0] res_primary,
  input  wire logic [17:0] res_imag,
  input  wire logic [5:0]  adc_mux,
  input  wire logic [1:0]  seq_id,
  output logic             res_ready,
  // result queue
  output logic             q_wr_valid,
  output logic [31:0]      q_wr_data,
  output logic             q_clear,
  input  wire logic        q_empty,
  input  wire logic [31:0] q_rdata,
  output logic             q_pop,
  // front-end freeze and interrupt
  output logic             execution_freeze,
  output logic             irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]          write_command_spacing_divider;
    logic                execution_freeze;
    logic                stop_on_command_underflow;
    logic                command_engine_enable;
    logic [2:0]          result_source_select;
    logic                result_queue_enable;
    logic                rsv_hi;
    logic [10:0]         rsv_lo;
    logic [7:0]          crc;
    logic [29:0]         timeout;
    logic [sfcr_pkg::IRQ_W-1:0] irq_status;
    logic [sfcr_pkg::IRQ_W-1:0] irq_mask;
    sfcr_pkg::sfcr_eng_t eng;
    logic [7:0]          space_cnt;
    logic [31:0]         rdata;
    logic                exec_valid;
    logic [31:0]         exec_word;
  } sfcr_state_t;

  sfcr_state_t s;
  sfcr_state_t next_s;
  logic [7:0]  crc_next;
  logic [sfcr_pkg::IRQ_W-1:0] events;

  // ****************************************
  // checksum step and result packing
  // ****************************************
  sfcr_crc8 i_sfcr_crc8 (
    .crc_in  (s.crc),
    .word    (cmd_data),
    .crc_out (crc_next)
  );

  // packing follows the queue enable and the freeze
  sfcr_result_pack i_sfcr_result_pack (
    .clk         (clk),
    .rst_n       (rst_n),
    .freeze      (s.execution_freeze),
    .enable      (s.result_queue_enable),
    .src_sel     (s.result_source_select),
    .res_valid   (res_valid),
    .res_primary (res_primary),
    .res_imag    (res_imag),
    .adc_mux     (adc_mux),
    .seq_id      (seq_id),
    .res_ready   (res_ready),
    .wr_valid    (q_wr_valid),
    .wr_data     (q_wr_data)
  );

  // ****************************************
  // register write helper
  // ****************************************
  // only register fields move; the reserved bits rsv_hi and rsv_lo are stored as written
  function automatic sfcr_state_t put(input sfcr_state_t st,
                                      input logic [15:0] a,
                                      input logic [31:0] d);
    sfcr_state_t r;
    r = st;
    case (a)
      sfcr_pkg::ADDR_SEQ_CONTROL: begin
        r.write_command_spacing_divider = d[sfcr_pkg::SC_DIV_LSB +: 8];
        r.execution_freeze          = d[sfcr_pkg::SC_FREEZE];
        r.stop_on_command_underflow = d[sfcr_pkg::SC_STOP_UF];
        r.command_engine_enable     = d[sfcr_pkg::SC_ENABLE];
      end
      sfcr_pkg::ADDR_FIFO_CONFIG: begin
        r.result_source_select = d[sfcr_pkg::FC_SRC_LSB +: 3];
        r.rsv_hi               = d[sfcr_pkg::FC_RSV_HI];
        r.result_queue_enable  = d[sfcr_pkg::FC_QEN];
        r.rsv_lo               = d[10:0];
      end
      default: r = st;
    endcase
    return r;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.rdata      = 32'h0000_0000;
    next_s.exec_valid = 1'b0;
    events  = '0;
    cmd_pop = 1'b0;
    q_pop   = 1'b0;

    // host first, sequencer after it, so the sequencer write wins
    if (reg_wr && !(seq_wr && seq_addr == reg_addr)) begin
      next_s = put(next_s, reg_addr, reg_wdata);
    end
    if (seq_wr) begin
      next_s = put(next_s, seq_addr, seq_wdata);
    end

    // mask write and write-one-to-clear of the sticky status
    if (reg_wr && reg_addr == sfcr_pkg::ADDR_IRQ_MASK) begin
      next_s.irq_mask = reg_wdata[sfcr_pkg::IRQ_W-1:0];
    end
    if (reg_wr && reg_addr == sfcr_pkg::ADDR_IRQ_STATUS) begin
      next_s.irq_status = s.irq_status & ~reg_wdata[sfcr_pkg::IRQ_W-1:0];
    end

    // register reads, data stands one cycle later
    if (reg_rd) begin
      case (reg_addr)
        sfcr_pkg::ADDR_SEQ_CONTROL: begin
          next_s.rdata = {16'h0000, s.write_command_spacing_divider, 3'h0,
                          s.execution_freeze, 2'h0,
                          s.stop_on_command_underflow,
                          s.command_engine_enable};
        end
        sfcr_pkg::ADDR_FIFO_CONFIG: begin
          next_s.rdata = {16'h0000, s.result_source_select, s.rsv_hi,
                          s.result_queue_enable, s.rsv_lo};
        end
        sfcr_pkg::ADDR_CHECKSUM: begin
          next_s.rdata = {24'h00_0000, s.crc};
        end
        sfcr_pkg::ADDR_WATCHDOG: begin
          next_s.rdata = {2'b00, s.timeout};
        end
        sfcr_pkg::ADDR_QUEUE_READ: begin
          // a frozen queue neither pops nor flags; it reads zero
          if (!s.execution_freeze) begin
            if (s.result_queue_enable && !q_empty) begin
              q_pop        = 1'b1;
              next_s.rdata = q_rdata;
            end else begin
              events[sfcr_pkg::IRQ_QUEUE_UF] = 1'b1;
            end
          end
        end
        sfcr_pkg::ADDR_IRQ_STATUS: begin
          next_s.rdata = {{(32-sfcr_pkg::IRQ_W){1'b0}}, s.irq_status};
        end
        sfcr_pkg::ADDR_IRQ_MASK: begin
          next_s.rdata = {{(32-sfcr_pkg::IRQ_W){1'b0}}, s.irq_mask};
        end
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // command engine; everything holds while frozen
    if (!s.execution_freeze) begin
      case (s.eng)
        sfcr_pkg::ENG_IDLE: begin
          if (s.command_engine_enable) begin
            next_s.eng = sfcr_pkg::ENG_FETCH;
          end
        end
        sfcr_pkg::ENG_FETCH: begin
          if (!s.command_engine_enable) begin
            next_s.eng = sfcr_pkg::ENG_IDLE;
          end else if (cmd_empty) begin
            if (s.stop_on_command_underflow) begin
              next_s.command_engine_enable = 1'b0;
              next_s.eng = sfcr_pkg::ENG_IDLE;
              events[sfcr_pkg::IRQ_CMD_UF] = 1'b1;
            end else begin
              // no stop: stay here and try again next cycle
              next_s.eng = sfcr_pkg::ENG_FETCH;
            end
          end else begin
            cmd_pop           = 1'b1;
            next_s.exec_valid = 1'b1;
            next_s.exec_word  = cmd_data;
            next_s.crc        = crc_next;
            // only register writes are spaced; waits time themselves
            if (cmd_is_write && s.write_command_spacing_divider != 8'h00) begin
              next_s.space_cnt = s.write_command_spacing_divider;
              next_s.eng       = sfcr_pkg::ENG_SPACE;
            end
          end
        end
        sfcr_pkg::ENG_SPACE: begin
          if (!s.command_engine_enable) begin
            next_s.eng = sfcr_pkg::ENG_IDLE;
          end else if (aclk_tick) begin
            next_s.space_cnt = s.space_cnt - 8'h01;
            if (s.space_cnt == 8'h01) begin
              next_s.eng = sfcr_pkg::ENG_FETCH;
            end
          end
        end
        default: next_s.eng = sfcr_pkg::ENG_IDLE;
      endcase

      // timeout runs while the engine is on and clears when it is off
      if (s.command_engine_enable) begin
        next_s.timeout = s.timeout + 30'h0000_0001;
      end else begin
        next_s.timeout = 30'h0000_0000;
      end
    end

    // a new event wins over a clear in the same cycle
    next_s.irq_status = next_s.irq_status | events;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.stop_on_command_underflow <= sfcr_pkg::SEQ_CONTROL_RESET[sfcr_pkg::SC_STOP_UF];
      s.rsv_hi <= sfcr_pkg::FIFO_CONFIG_RESET[sfcr_pkg::FC_RSV_HI];
      s.rsv_lo <= sfcr_pkg::FIFO_CONFIG_RESET[10:0];
      s.crc    <= sfcr_pkg::CRC_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata        = s.rdata;
  assign exec_valid       = s.exec_valid;
  assign exec_word        = s.exec_word;
  assign q_clear          = !s.result_queue_enable;
  assign execution_freeze = s.execution_freeze;
  // level interrupt, high while any unmasked sticky bit is set
  assign irq              = |(s.irq_status & s.irq_mask);

endmodule

// ---- sfcr_pkg.sv ----
/*
  constants and types for the sequencer and result queue control registers.
  assumes a 40 MHz clk, byte addresses on a 16-bit register port.
*/
// Function
// - divider spaces register-write commands, waits unaffected
// - freeze bit stops sequencer, accelerators and queues
// - stop-on-underflow set: sequencer stops on empty
// - stop-on-underflow clear: sequencer keeps retrying fetch
// - engine enable runs fetch and execute, resets off
// - source select picks sinc3, transform, sinc2, variance, mean
// - transform result: real and imaginary, 18 bits
// - variance: 30 bits over two queue words
// - sinc2 result carries 16 data bits
// - mean result carries 16 data bits
// - queue enable low holds queue empty, no transfers
// - queue enable high lets queue run normally
// - read-only CRC-8 over executed commands, reset 0x1
// - read-only 30-bit timeout counter, reset zero
// - empty queue read returns zero, flags underflow
// - sequencer write beats simultaneous host write silently
package sfcr_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] ADDR_SEQ_CONTROL = 16'h2004;
  localparam logic [15:0] ADDR_FIFO_CONFIG = 16'h2008;
  localparam logic [15:0] ADDR_CHECKSUM    = 16'h2060;
  localparam logic [15:0] ADDR_WATCHDOG    = 16'h2068;
  localparam logic [15:0] ADDR_QUEUE_READ  = 16'h206c;
  localparam logic [15:0] ADDR_IRQ_STATUS  = 16'h2080;
  localparam logic [15:0] ADDR_IRQ_MASK    = 16'h2084;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned SC_ENABLE   = 0;
  localparam int unsigned SC_STOP_UF  = 1;
  localparam int unsigned SC_FREEZE   = 4;
  localparam int unsigned SC_DIV_LSB  = 8;
  localparam int unsigned FC_RSV_HI   = 12;
  localparam int unsigned FC_QEN      = 11;
  localparam int unsigned FC_SRC_LSB  = 13;
  localparam logic [31:0] SEQ_CONTROL_RESET = 32'h0000_0002;
  localparam logic [31:0] FIFO_CONFIG_RESET = 32'h0000_1010;
  localparam logic [7:0]  CRC_RESET         = 8'h01;
  localparam logic [7:0]  CRC_POLY          = 8'h07;

  // interrupt status bits
  localparam int unsigned IRQ_QUEUE_UF = 0;
  localparam int unsigned IRQ_CMD_UF   = 1;
  localparam int unsigned IRQ_W        = 2;

  // ****************************************
  // result sources and channel ids
  // ****************************************
  localparam logic [2:0] SRC_TRANSFORM = 3'h2;
  localparam logic [2:0] SRC_SINC2     = 3'h3;
  localparam logic [2:0] SRC_VARIANCE  = 3'h4;
  localparam logic [2:0] SRC_MEAN      = 3'h5;
  localparam logic [4:0] CH_TRANSFORM  = 5'h1f;
  localparam logic [6:0] CH_MEAN       = 7'h78;
  localparam logic [6:0] CH_VARIANCE   = 7'h74;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_FETCH = 2'b01,
    ENG_SPACE = 2'b10
  } sfcr_eng_t;

  typedef enum logic [0:0] {
    PK_IDLE   = 1'b0,
    PK_SECOND = 1'b1
  } sfcr_pack_t;

endpackage

// ---- sfcr_crc8.sv ----
/*
  combinational CRC-8 step over one 32-bit command word, msb first.
  assumes the caller registers the result.
*/
module sfcr_crc8 (
  // running value and word
  input  wire logic [7:0]  crc_in,
  input  wire logic [31:0] word,
  // next value
  output logic [7:0]       crc_out
);

  // ****************************************
  // bit-serial fold, unrolled by the loop
  // ****************************************
  always_comb begin
    logic [7:0] c;
    c = crc_in;
    for (int i = 31; i >= 0; i--) begin
      if (c[7] ^ word[i]) begin
        c = {c[6:0], 1'b0} ^ sfcr_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule

// ---- sfcr_result_pack.sv ----
/*
  packs one accelerator result into result queue words by source.
  assumes the queue takes every word it is offered while enabled.
*/
module sfcr_result_pack (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        freeze,
  input  wire logic        enable,
  input  wire logic [2:0]  src_sel,
  // result in
  input  wire logic        res_valid,
  input  wire logic [29:0] res_primary,
  input  wire logic [17:0] res_imag,
  input  wire logic [5:0]  adc_mux,
  input  wire logic [1:0]  seq_id,
  output logic             res_ready,
  // queue words out
  output logic             wr_valid,
  output logic [31:0]      wr_data
);

  typedef struct packed {
    sfcr_pkg::sfcr_pack_t stage;
    logic [31:0]          pending;
    logic                 wr_valid;
    logic [31:0]          wr_data;
  } sfcr_pk_state_t;

  sfcr_pk_state_t s;
  sfcr_pk_state_t next_s;

  // ecc field left zero here; it is added where the word is stored
  always_comb begin
    next_s = s;
    next_s.wr_valid = 1'b0;
    if (!enable) begin
      next_s = '0;
    end else if (!freeze) begin
      case (s.stage)
        sfcr_pkg::PK_IDLE: begin
          if (res_valid) begin
            next_s.wr_valid = 1'b1;
            case (src_sel)
              sfcr_pkg::SRC_TRANSFORM: begin
                next_s.wr_data = {7'h00, seq_id, sfcr_pkg::CH_TRANSFORM, res_primary[17:0]};
                next_s.pending = {7'h00, seq_id, sfcr_pkg::CH_TRANSFORM, res_imag};
                next_s.stage   = sfcr_pkg::PK_SECOND;
              end
              sfcr_pkg::SRC_VARIANCE: begin
                next_s.wr_data = {7'h00, seq_id, sfcr_pkg::CH_VARIANCE, res_primary[15:0]};
                next_s.pending = {7'h00, seq_id, sfcr_pkg::CH_VARIANCE, 2'b00, res_primary[29:16]};
                next_s.stage   = sfcr_pkg::PK_SECOND;
              end
              sfcr_pkg::SRC_SINC2: next_s.wr_data = {7'h00, seq_id, 1'b1, adc_mux, res_primary[15:0]};
              sfcr_pkg::SRC_MEAN:  next_s.wr_data = {7'h00, seq_id, sfcr_pkg::CH_MEAN, res_primary[15:0]};
              default:             next_s.wr_data = {7'h00, seq_id, 1'b0, adc_mux, res_primary[15:0]};
            endcase
          end
        end
        sfcr_pkg::PK_SECOND: begin
          next_s.wr_valid = 1'b1;
          next_s.wr_data  = s.pending;
          next_s.stage    = sfcr_pkg::PK_IDLE;
        end
        default: next_s.stage = sfcr_pkg::PK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // a second word blocks new results for one cycle
  assign res_ready = enable && !freeze && (s.stage == sfcr_pkg::PK_IDLE);
  assign wr_valid  = s.wr_valid;
  assign wr_data   = s.wr_data;

endmodule

// ---- sfcr_regs_sva.sv ----
/*
  checker for sfcr_regs: port timing of register, engine and queue paths.
  assumes sfcr_pkg is compiled first; bound to every sfcr_regs instance.
*/
// ****************************************
// port checker
// ****************************************
module sfcr_regs_chk (
  // clock and reset
  input logic        clk,
  input logic        rst_n,
  // register port
  input logic [15:0] reg_addr,
  input logic        reg_rd,
  input logic [31:0] reg_rdata,
  // command engine
  input logic        cmd_empty,
  input logic [31:0] cmd_data,
  input logic        cmd_pop,
  input logic        exec_valid,
  input logic [31:0] exec_word,
  // result path
  input logic        res_valid,
  input logic        res_ready,
  input logic        q_wr_valid,
  input logic [31:0] q_wr_data,
  input logic        q_clear,
  input logic        q_empty,
  input logic [31:0] q_rdata,
  input logic        q_pop,
  input logic        execution_freeze
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // steps of the fetch, queue read and result take
  sequence s_pop; cmd_pop && !cmd_empty; endsequence
  sequence s_qhit; q_pop && reg_rd && reg_addr == sfcr_pkg::ADDR_QUEUE_READ; endsequence
  sequence s_take; res_valid && res_ready; endsequence

  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_exec; s_pop |=> exec_valid && exec_word == $past(cmd_data); endproperty
  a_exec: assert property (p_exec) else $error("popped word not executed");
  property p_exec_src; exec_valid |-> $past(cmd_pop); endproperty
  a_exec_src: assert property (p_exec_src) else $error("execution without pop");
  property p_pop_ok; cmd_pop |-> !cmd_empty && !execution_freeze; endproperty
  a_pop_ok: assert property (p_pop_ok) else $error("pop while empty or frozen");
  property p_freeze; execution_freeze |-> !res_ready && !q_pop && !cmd_pop; endproperty
  a_freeze: assert property (p_freeze) else $error("activity while frozen");
  property p_clear; q_clear |-> !res_ready && !q_pop; endproperty
  a_clear: assert property (p_clear) else $error("queue moves while disabled");
  property p_take; s_take |=> q_wr_valid; endproperty
  a_take: assert property (p_take) else $error("result not written");
  property p_hdr; q_wr_valid |-> q_wr_data[31:25] == 7'h00; endproperty
  a_hdr: assert property (p_hdr) else $error("queue word top bits set");
  property p_qpop; q_pop |-> reg_rd && reg_addr == sfcr_pkg::ADDR_QUEUE_READ && !q_empty; endproperty
  a_qpop: assert property (p_qpop) else $error("stray queue pop");
  property p_qdata; s_qhit |=> reg_rdata == $past(q_rdata); endproperty
  a_qdata: assert property (p_qdata) else $error("queue head not returned");
  property p_qempty; reg_rd && reg_addr == sfcr_pkg::ADDR_QUEUE_READ && q_empty |=> reg_rdata == 32'h0; endproperty
  a_qempty: assert property (p_qempty) else $error("empty queue read not zero");
endmodule

bind sfcr_regs sfcr_regs_chk i_sfcr_regs_chk (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cmd_empty(cmd_empty), .cmd_data(cmd_data), .cmd_pop(cmd_pop), .exec_valid(exec_valid),
  .exec_word(exec_word), .res_valid(res_valid), .res_ready(res_ready), .q_wr_valid(q_wr_valid),
  .q_wr_data(q_wr_data), .q_clear(q_clear), .q_empty(q_empty), .q_rdata(q_rdata), .q_pop(q_pop),
  .execution_freeze(execution_freeze));

// ---- sfcr_regs_bench.sv ----
/*
  bench for sfcr_regs: register read and write tasks and check sequences.
  assumes sfcr_pkg and the bound checker; timer tick and command kind driven here.
*/
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module sfcr_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_n, reg_wr, reg_rd, seq_wr, cmd_empty, res_valid, q_empty, aclk_tick, cmd_is_write;
  logic        cmd_pop, exec_valid, res_ready, q_wr_valid, q_clear, q_pop, execution_freeze, irq;
  logic [1:0]  sid;
  logic [15:0] reg_addr, seq_addr;
  logic [31:0] reg_wdata, seq_wdata, cmd_data, q_rdata, reg_rdata, exec_word, q_wr_data, t0, t1, t2;
  int          bad_count, n_tests;
  localparam logic [29:0] PRIM = 30'h2bcd_1234;
  localparam logic [17:0] IMAG = 18'h2_5a5a;
  localparam logic [5:0]  MUX  = 6'h15;

  sfcr_regs i_sfcr_regs (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_wr(seq_wr), .seq_addr(seq_addr),
    .seq_wdata(seq_wdata), .aclk_tick(aclk_tick), .cmd_empty(cmd_empty), .cmd_data(cmd_data),
    .cmd_is_write(cmd_is_write), .cmd_pop(cmd_pop), .exec_valid(exec_valid), .exec_word(exec_word),
    .res_valid(res_valid), .res_primary(PRIM), .res_imag(IMAG), .adc_mux(MUX), .seq_id(sid),
    .res_ready(res_ready), .q_wr_valid(q_wr_valid), .q_wr_data(q_wr_data), .q_clear(q_clear),
    .q_empty(q_empty), .q_rdata(q_rdata), .q_pop(q_pop), .execution_freeze(execution_freeze),
    .irq(irq));

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // ****************************************
  // access tasks and expectations
  // ****************************************
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data is looked at mid-cycle, in the only cycle it stands
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic crd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK("read", e, d)
  endtask

  // msb-first crc-8 over one command word
  function automatic logic [7:0] crc8(input logic [31:0] w);
    logic [7:0] c;
    c = sfcr_pkg::CRC_RESET;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? sfcr_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  function automatic logic [31:0] qword(input logic [2:0] s, input logic [1:0] id, input bit two);
    case (s)
      sfcr_pkg::SRC_TRANSFORM: return {7'h0, id, sfcr_pkg::CH_TRANSFORM, two ? IMAG : PRIM[17:0]};
      sfcr_pkg::SRC_SINC2:     return {7'h0, id, 1'b1, MUX, PRIM[15:0]};
      sfcr_pkg::SRC_VARIANCE:  return two ? {18'h0, PRIM[29:16]} : {7'h0, id, sfcr_pkg::CH_VARIANCE, PRIM[15:0]};
      sfcr_pkg::SRC_MEAN:      return {7'h0, id, sfcr_pkg::CH_MEAN, PRIM[15:0]};
      default:                 return {7'h0, id, 1'b0, MUX, PRIM[15:0]};
    endcase
  endfunction

  // one result in, one or two queue words out on the following cycles
  task automatic push(input logic [2:0] s);
    logic two;
    two = (s == sfcr_pkg::SRC_TRANSFORM) || (s == sfcr_pkg::SRC_VARIANCE);
    @(negedge clk);
    `CHK("ready", 1'b1, res_ready)
    @(posedge clk);
    res_valid <= 1'b1;
    sid       <= s[1:0];
    @(posedge clk);
    res_valid <= 1'b0;
    @(negedge clk);
    `CHK("word", qword(s, s[1:0], 0), q_wr_valid ? q_wr_data : 32'hx)
    if (two) begin
      @(negedge clk);
      `CHK("word2", qword(s, s[1:0], 1), (q_wr_valid ? q_wr_data : 32'hx) & (s == 3'h4 ? 32'hffff : '1))
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #100us;
    bad_count++;
    report_and_stop();
  end

  // ****************************************
  // sequence of checks
  // ****************************************
  initial begin
    {rst_n, reg_wr, reg_rd, seq_wr, res_valid, sid, aclk_tick, cmd_is_write} = '0;
    {reg_addr, seq_addr, reg_wdata, seq_wdata, q_rdata} = '0;
    cmd_data  = 32'h8c3a_5e01;
    cmd_empty = 1'b1;
    q_empty   = 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    crd(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_0002);
    crd(sfcr_pkg::ADDR_FIFO_CONFIG, 32'h0000_1010);
    crd(sfcr_pkg::ADDR_CHECKSUM, 32'h0000_0001);
    crd(sfcr_pkg::ADDR_WATCHDOG, 32'h0);
    wr(sfcr_pkg::ADDR_SEQ_CONTROL, 32'hffff_ffee);
    crd(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_ff02);
    wr(sfcr_pkg::ADDR_FIFO_CONFIG, 32'hffff_ffff);
    crd(sfcr_pkg::ADDR_FIFO_CONFIG, 32'h0000_ffff);
    wr(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_0002);
    wr(sfcr_pkg::ADDR_CHECKSUM, 32'h0000_00ff);
    crd(sfcr_pkg::ADDR_CHECKSUM, 32'h0000_0001);
    // host and sequencer write the same register at once
    @(posedge clk);
    reg_addr  <= sfcr_pkg::ADDR_FIFO_CONFIG;
    reg_wdata <= 32'h0000_1010;
    reg_wr    <= 1'b1;
    seq_addr  <= sfcr_pkg::ADDR_FIFO_CONFIG;
    seq_wdata <= 32'h0000_1800;
    seq_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    seq_wr <= 1'b0;
    crd(sfcr_pkg::ADDR_FIFO_CONFIG, 32'h0000_1800);
    // every source code, queue enabled
    for (int s = 0; s < 8; s++) begin
      wr(sfcr_pkg::ADDR_FIFO_CONFIG, 32'h0000_1800 | (32'(s) << 13));
      push(3'(s));
    end
    wr(sfcr_pkg::ADDR_FIFO_CONFIG, 32'h0000_1000);
    @(negedge clk);
    `CHK("clear", 1'b1, q_clear)
    `CHK("idle", 1'b0, res_ready)
    // queue reads, underflow flag and its interrupt
    wr(sfcr_pkg::ADDR_FIFO_CONFIG, 32'h0000_1800);
    q_empty <= 1'b0;
    q_rdata <= 32'h0123_abcd;
    crd(sfcr_pkg::ADDR_QUEUE_READ, 32'h0123_abcd);
    @(posedge clk);
    q_empty <= 1'b1;
    crd(sfcr_pkg::ADDR_QUEUE_READ, 32'h0);
    crd(sfcr_pkg::ADDR_IRQ_STATUS, 32'h1);
    wr(sfcr_pkg::ADDR_IRQ_MASK, 32'h1);
    @(negedge clk);
    `CHK("irq", 1'b1, irq)
    wr(sfcr_pkg::ADDR_IRQ_STATUS, 32'h1);
    @(negedge clk);
    `CHK("irq0", 1'b0, irq)
    // one command, then stop on the empty fetch
    @(posedge clk);
    cmd_empty <= 1'b0;
    wr(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_0003);
    repeat (8) begin
      @(negedge clk);
      if (cmd_pop === 1'b1) break;
    end
    @(posedge clk);
    cmd_empty <= 1'b1;
    @(negedge clk);
    `CHK("exec", cmd_data, exec_valid ? exec_word : 32'hx)
    repeat (4) @(posedge clk);
    crd(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_0002);
    crd(sfcr_pkg::ADDR_IRQ_STATUS, 32'h2);
    crd(sfcr_pkg::ADDR_CHECKSUM, {24'h0, crc8(cmd_data)});
    // retry on empty, counter runs, freeze holds it
    wr(sfcr_pkg::ADDR_IRQ_STATUS, 32'h2);
    wr(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    rd(sfcr_pkg::ADDR_WATCHDOG, t0);
    rd(sfcr_pkg::ADDR_WATCHDOG, t1);
    `CHK("tick", 32'h2, t1 - t0)
    crd(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_0001);
    crd(sfcr_pkg::ADDR_IRQ_STATUS, 32'h0);
    wr(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_0011);
    @(negedge clk);
    `CHK("frozen", 2'b10, {execution_freeze, res_ready})
    rd(sfcr_pkg::ADDR_WATCHDOG, t0);
    rd(sfcr_pkg::ADDR_WATCHDOG, t1);
    `CHK("hold", t0, t1)
    wr(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_0001);
    rd(sfcr_pkg::ADDR_WATCHDOG, t2);
    `CHK("resume", 1'b1, t2 > t1 && t2 < t1 + 8)
    // a write command waits for two divider ticks before the next fetch
    wr(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0000_0201);
    cmd_is_write <= 1'b1;
    cmd_empty    <= 1'b0;
    repeat (4) @(posedge clk);
    aclk_tick <= 1'b1;
    @(negedge clk);
    `CHK("wait", 1'b0, cmd_pop)
    @(posedge clk);
    @(negedge clk);
    `CHK("wait1", 1'b0, cmd_pop)
    @(posedge clk);
    aclk_tick <= 1'b0;
    @(negedge clk);
    `CHK("spaced", 1'b1, cmd_pop)
    @(posedge clk);
    {cmd_empty, cmd_is_write} <= 2'b10;
    wr(sfcr_pkg::ADDR_SEQ_CONTROL, 32'h0);
    crd(sfcr_pkg::ADDR_WATCHDOG, 32'h0);
    report_and_stop();
  end
endmodule
